// ---- hdl/cla_addr_win.sv ----
// Filters incoming requests to the small address component's window
`timescale 1ns/1ps
module cla_addr_win #(
  parameter int NARROW_AW = 32,
  parameter int WIDE_AW = 40,
  parameter logic [WIDE_AW-NARROW_AW-1:0] WIN_BASE = '0
) (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // Incoming side
  input logic in_valid,
  output logic in_ready,
  input cla_pkg::cla_op_e in_op,
  input logic [WIDE_AW-1:0] in_addr,
  output logic in_drop,
  // Small component side
  output logic sm_valid,
  input logic sm_ready,
  output cla_pkg::cla_op_e sm_op,
  output logic [NARROW_AW-1:0] sm_addr
);
  import cla_pkg::*;
  logic hit; // Upper bits match the window
  logic take; // Incoming handshake
  logic sm_valid_reg, sm_valid_next;
  logic drop_reg, drop_next;
  cla_op_e op_reg, op_next;
  logic [NARROW_AW-1:0] addr_reg, addr_next;

  // One holding stage; refilled in the cycle it empties
  always_comb
  begin
    hit = (in_addr[WIDE_AW-1:NARROW_AW] == WIN_BASE);
    take = in_valid & in_ready;
    sm_valid_next = sm_valid_reg & ~sm_ready;
    op_next = op_reg;
    addr_next = addr_reg;
    drop_next = take & ~hit;
    if (take && hit)
    begin
      sm_valid_next = 1'b1;
      op_next = in_op;
      addr_next = in_addr[NARROW_AW-1:0];
    end
  end

  // Registers only
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sm_valid_reg <= 1'b0;
      drop_reg <= 1'b0;
      op_reg <= OP_READ_NO_SNOOP;
      addr_reg <= '0;
    end
    else
    begin
      sm_valid_reg <= sm_valid_next;
      drop_reg <= drop_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
    end
  end

  assign in_ready = ~sm_valid_reg | sm_ready;
  assign sm_valid = sm_valid_reg;
  assign sm_op = op_reg;
  assign sm_addr = addr_reg;
  assign in_drop = drop_reg;

  chk_win_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
    (take && !hit && !sm_valid_reg) |=> (!sm_valid && in_drop))
    else $error("out-of-window request was forwarded");
endmodule : cla_addr_win

// ---- hdl/cla_defs.svh ----
// Elaboration constants for the coherent line size adapter
`ifndef CLA_DEFS_SVH
`define CLA_DEFS_SVH
// ----------------------------------------
// Line sizes in bytes
// ----------------------------------------
`define CLA_NARROW_LINE 32
`define CLA_WIDE_LINE 64
// ----------------------------------------
// Physical address widths and window
// ----------------------------------------
`define CLA_NARROW_AW 32
`define CLA_WIDE_AW 40
`define CLA_WIN_BASE 8'h00
// ----------------------------------------
// Cache attribute field positions
// ----------------------------------------
`define CLA_CACHE_ALLOC_LO 2
`define CLA_CACHE_ALLOC_HI 3
`endif

// ---- hdl/cla_pkg.sv ----
// Types shared by the coherent line size adapter modules
package cla_pkg;
  // ----------------------------------------
  // Transaction opcodes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_READ_NO_SNOOP = 4'h0,
    OP_READ_ONCE = 4'h1,
    OP_READ_CLEAN = 4'h2,
    OP_READ_NSD = 4'h3,
    OP_READ_SHARED = 4'h4,
    OP_READ_UNIQUE = 4'h5,
    OP_CLEAN_UNIQUE = 4'h6,
    OP_CLEAN_SHARED = 4'h7,
    OP_CLEAN_INVALID = 4'h8,
    OP_MAKE_UNIQUE = 4'h9,
    OP_MAKE_INVALID = 4'hA,
    OP_WRITE_NO_SNOOP = 4'hB,
    OP_WRITE_UNIQUE = 4'hC,
    OP_WRITE_BACK = 4'hD,
    OP_WRITE_CLEAN = 4'hE,
    OP_WRITE_LINE_UNIQUE = 4'hF
  } cla_op_e;
  // ----------------------------------------
  // Shareability domains
  // ----------------------------------------
  typedef enum logic [1:0] {
    DOM_NSH = 2'h0,
    DOM_INNER = 2'h1,
    DOM_OUTER = 2'h2,
    DOM_SYS = 2'h3
  } cla_dom_e;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ISSUE = 3'h1,
    ST_WAIT = 3'h2,
    ST_WB = 3'h3,
    ST_RESP = 3'h4
  } cla_state_e;
endpackage : cla_pkg

// ---- hdl/cla_rsp_if.sv ----
// Interface carrying part responses to the response merger
`timescale 1ns/1ps
interface cla_rsp_if;
  logic clear; // Start of a new transaction
  logic upd; // One part response taken
  logic shared; // Part reported shared
  logic dirty; // Part passed dirty
  logic acc_shared; // Accumulated shared
  logic acc_dirty; // Accumulated dirty
  modport ctl (output clear, output upd, output shared, output dirty,
    input acc_shared, input acc_dirty);
  modport mrg (input clear, input upd, input shared, input dirty,
    output acc_shared, output acc_dirty);
endinterface : cla_rsp_if

// ---- hdl/cla_rsp_merge.sv ----
// Accumulates shared and dirty state across the parts of a transaction
`timescale 1ns/1ps
module cla_rsp_merge (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // Merge port
  cla_rsp_if.mrg rif
);
  import cla_pkg::*;
  logic shared_reg, shared_next; // Any part shared
  logic dirty_reg, dirty_next; // Any part dirty

  // Set wins over clear so no part is lost
  always_comb
  begin
    shared_next = (rif.clear ? 1'b0 : shared_reg) | (rif.upd & rif.shared);
    dirty_next = (rif.clear ? 1'b0 : dirty_reg) | (rif.upd & rif.dirty);
  end

  // Registers only
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      shared_reg <= 1'b0;
      dirty_reg <= 1'b0;
    end
    else
    begin
      shared_reg <= shared_next;
      dirty_reg <= dirty_next;
    end
  end

  assign rif.acc_shared = shared_reg;
  assign rif.acc_dirty = dirty_reg;
endmodule : cla_rsp_merge

// ---- hdl/cla_top.sv ----
// Coherent line size and address width adapter, top level
// Function
// - Widen narrow-line reads to the wide line
// - Write back dirty surplus of widened reads
// - Widen cleans, write back returned dirty data
// - Widened MakeUnique/MakeInvalid issue CleanInvalid
// - Split full-line wide snooping requests into narrow parts
// - Combine all part results into one response
// - Issue parts back to back, nothing between
// - Any part shared makes whole line shared
// - Any part dirty makes whole line dirty
// - Never leave a line dirty twice
// - Accept partial sizes for six request types
// - Other requests must be full line
// - Snoops full line; partial WriteUnique snoops CleanInvalid
// - Small space sits in an aligned window
// - Prepend window bits to outgoing addresses
// - Strip window bits from matching incoming requests
// - Suppress incoming requests outside the window
// - Cache attribute picks downstream maintenance
// - Domain picks which peer caches snoop
// - Cleans write back; MakeInvalid only invalidates (a widened MakeInvalid goes out as CleanInvalid and writes back)
// - Untaken dirty ownership causes memory write (unwidened MakeUnique and MakeInvalid drop the dirty data instead)
`timescale 1ns/1ps
`include "cla_defs.svh"
module cla_top #(
  parameter int NARROW_LINE = `CLA_NARROW_LINE,
  parameter int WIDE_LINE = `CLA_WIDE_LINE,
  parameter int NARROW_AW = `CLA_NARROW_AW,
  parameter int WIDE_AW = `CLA_WIDE_AW,
  parameter logic [WIDE_AW-NARROW_AW-1:0] WIN_BASE = `CLA_WIN_BASE
) (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // Request from the initiating master
  input logic up_valid,
  output logic up_ready,
  input cla_pkg::cla_op_e up_op,
  input logic [NARROW_AW-1:0] up_addr,
  input logic up_wide,
  input logic up_full,
  input logic [3:0] up_cache,
  input cla_pkg::cla_dom_e up_domain,
  // Downstream request or snoop
  output logic dn_valid,
  input logic dn_ready,
  output cla_pkg::cla_op_e dn_op,
  output logic [WIDE_AW-1:0] dn_addr,
  output logic dn_full,
  output logic [3:0] dn_cache,
  output cla_pkg::cla_dom_e dn_domain,
  output logic dn_peer_snoop,
  output logic dn_ds_maint,
  // Per-part response
  input logic sr_valid,
  output logic sr_ready,
  input logic sr_shared,
  input logic sr_dirty,
  // Memory update write
  output logic wb_valid,
  input logic wb_ready,
  output logic [WIDE_AW-1:0] wb_addr,
  // Response to the initiating master
  output logic rsp_valid,
  input logic rsp_ready,
  output logic rsp_shared,
  output logic rsp_dirty,
  output logic rsp_err,
  // Incoming toward the small address component
  input logic in_valid,
  output logic in_ready,
  input cla_pkg::cla_op_e in_op,
  input logic [WIDE_AW-1:0] in_addr,
  output logic in_drop,
  output logic sm_valid,
  input logic sm_ready,
  output cla_pkg::cla_op_e sm_op,
  output logic [NARROW_AW-1:0] sm_addr
);
  import cla_pkg::*;

  // ----------------------------------------
  // Derived sizes
  // ----------------------------------------
  localparam int NOFF = $clog2(NARROW_LINE); // Narrow line offset bits
  localparam int WOFF = $clog2(WIDE_LINE); // Wide line offset bits
  localparam int PARTS = WIDE_LINE / NARROW_LINE; // Narrow parts per wide line
  localparam int PCW = (PARTS > 1) ? $clog2(PARTS) : 1;
  localparam logic [PCW-1:0] LAST_PART = PCW'(PARTS - 1);
  localparam logic [WIDE_AW-1:0] PART_STEP = WIDE_AW'(NARROW_LINE);

  // ----------------------------------------
  // Opcode decoders
  // ----------------------------------------
  // Reads, cleans and makes that may grow to the wide line
  function automatic logic is_widenable(input cla_op_e op);
    case (op)
      OP_READ_ONCE, OP_READ_CLEAN, OP_READ_NSD, OP_READ_SHARED, OP_READ_UNIQUE,
      OP_CLEAN_UNIQUE, OP_CLEAN_SHARED, OP_CLEAN_INVALID,
      OP_MAKE_UNIQUE, OP_MAKE_INVALID: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_widenable

  // Requests allowed below a full line
  function automatic logic may_partial(input cla_op_e op);
    case (op)
      OP_READ_NO_SNOOP, OP_READ_ONCE, OP_WRITE_NO_SNOOP,
      OP_WRITE_UNIQUE, OP_WRITE_BACK, OP_WRITE_CLEAN: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : may_partial

  // Requests that need a snoop of peer caches
  function automatic logic is_snoop(input cla_op_e op);
    case (op)
      OP_READ_NO_SNOOP, OP_WRITE_NO_SNOOP, OP_WRITE_BACK, OP_WRITE_CLEAN: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction : is_snoop

  // Cache maintenance operations
  function automatic logic is_cmo(input cla_op_e op);
    case (op)
      OP_CLEAN_SHARED, OP_CLEAN_INVALID, OP_MAKE_INVALID: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_cmo

  // Requests whose response may carry dirty ownership
  function automatic logic may_pass(input cla_op_e op);
    case (op)
      OP_READ_NSD, OP_READ_SHARED, OP_READ_UNIQUE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : may_pass

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  cla_state_e state_reg, state_next; // Sequencer state
  cla_op_e op_reg, op_next; // Opcode as issued downstream
  cla_op_e orig_reg, orig_next; // Opcode as received
  logic [WIDE_AW-1:0] addr_reg, addr_next; // Current part address
  logic [WIDE_AW-1:0] base_reg, base_next; // Line base for the memory update
  logic full_reg, full_next;
  logic [3:0] cache_reg, cache_next;
  cla_dom_e dom_reg, dom_next;
  logic peer_reg, peer_next; // Peer caches to be snooped
  logic ds_reg, ds_next; // Downstream caches must act
  logic widen_reg, widen_next; // Request grown to the wide line
  logic split_reg, split_next; // Request cut into narrow parts
  logic [PCW-1:0] part_reg, part_next; // Part being issued
  logic err_reg, err_next;
  logic shared_reg, shared_next; // Response shared bit
  logic dirty_reg, dirty_next; // Response dirty bit

  // Decode helpers
  logic [WIDE_AW-1:0] full_addr; // Request address in the large space
  logic req_err; // Illegal size or domain
  logic req_widen;
  logic req_split;
  logic shared_all; // Merged shared including this part
  logic dirty_all; // Merged dirty including this part
  logic pass_ok; // Master may take the dirty line
  logic drop_dirty; // Invalidate-only, dirty discarded
  logic wb_need; // Adapter owns dirty data and must write it

  cla_rsp_if rif ();

  // ----------------------------------------
  // Part response merger
  // ----------------------------------------
  cla_rsp_merge u_merge (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rif(rif.mrg)
  );

  // ----------------------------------------
  // Incoming window filter
  // ----------------------------------------
  cla_addr_win #(
    .NARROW_AW(NARROW_AW),
    .WIDE_AW(WIDE_AW),
    .WIN_BASE(WIN_BASE)
  ) u_win (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_op(in_op),
    .in_addr(in_addr),
    .in_drop(in_drop),
    .sm_valid(sm_valid),
    .sm_ready(sm_ready),
    .sm_op(sm_op),
    .sm_addr(sm_addr)
  );

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  // Window base in the upper bits keeps the window aligned to its own size
  always_comb
  begin
    full_addr = {WIN_BASE, up_addr};
    req_err = (!up_full && !may_partial(up_op)) ||
      (is_cmo(up_op) && up_domain == DOM_SYS);
    req_widen = !up_wide && is_widenable(up_op);
    req_split = up_wide && up_full && is_snoop(up_op) && (PARTS > 1);
  end

  // ----------------------------------------
  // Completion decode
  // ----------------------------------------
  // A widened line is never handed dirty to a narrow master: the surplus
  // has no owner, so the adapter writes the line back itself
  always_comb
  begin
    shared_all = rif.acc_shared | sr_shared;
    dirty_all = rif.acc_dirty | sr_dirty;
    pass_ok = !widen_reg && may_pass(orig_reg) &&
      !(orig_reg == OP_READ_NSD && shared_all);
    drop_dirty = (op_reg == OP_MAKE_INVALID) || (op_reg == OP_MAKE_UNIQUE);
    wb_need = dirty_all && !pass_ok && !drop_dirty;
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  // Only this sequencer drives the downstream port, so parts of one
  // split line cannot be separated by another snoop
  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    orig_next = orig_reg;
    addr_next = addr_reg;
    base_next = base_reg;
    full_next = full_reg;
    cache_next = cache_reg;
    dom_next = dom_reg;
    peer_next = peer_reg;
    ds_next = ds_reg;
    widen_next = widen_reg;
    split_next = split_reg;
    part_next = part_reg;
    err_next = err_reg;
    shared_next = shared_reg;
    dirty_next = dirty_reg;
    rif.clear = 1'b0;
    rif.upd = 1'b0;
    rif.shared = sr_shared;
    rif.dirty = sr_dirty;
    case (state_reg)
      ST_IDLE:
      begin
        if (up_valid)
        begin
          rif.clear = 1'b1;
          orig_next = up_op;
          shared_next = 1'b0;
          dirty_next = 1'b0;
          part_next = '0;
          err_next = req_err;
          if (req_err)
          begin
            // Refused without any downstream traffic
            state_next = ST_RESP;
          end
          else
          begin
            widen_next = req_widen;
            split_next = req_split;
            op_next = up_op;
            if (req_widen && (up_op == OP_MAKE_UNIQUE || up_op == OP_MAKE_INVALID))
            begin
              op_next = OP_CLEAN_INVALID;
            end
            else if (!up_full && up_op == OP_WRITE_UNIQUE)
            begin
              op_next = OP_CLEAN_INVALID;
            end
            full_next = up_full | is_snoop(up_op);
            if (req_widen || req_split)
            begin
              addr_next = {full_addr[WIDE_AW-1:WOFF], {WOFF{1'b0}}};
            end
            else if (is_snoop(up_op))
            begin
              addr_next = {full_addr[WIDE_AW-1:NOFF], {NOFF{1'b0}}};
            end
            else
            begin
              addr_next = full_addr;
            end
            base_next = addr_next;
            cache_next = up_cache;
            dom_next = up_domain;
            peer_next = is_snoop(up_op) && (up_domain != DOM_NSH);
            ds_next = is_cmo(up_op) &&
              (|up_cache[`CLA_CACHE_ALLOC_HI:`CLA_CACHE_ALLOC_LO]);
            state_next = ST_ISSUE;
          end
        end
      end
      ST_ISSUE:
      begin
        if (dn_ready)
        begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (sr_valid)
        begin
          rif.upd = 1'b1;
          if (split_reg && part_reg != LAST_PART)
          begin
            // Next part follows at once
            part_next = part_reg + 1'b1;
            addr_next = addr_reg + PART_STEP;
            state_next = ST_ISSUE;
          end
          else
          begin
            shared_next = shared_all;
            dirty_next = dirty_all && pass_ok;
            state_next = wb_need ? ST_WB : ST_RESP;
          end
        end
      end
      ST_WB:
      begin
        if (wb_ready)
        begin
          state_next = ST_RESP;
        end
      end
      ST_RESP:
      begin
        if (rsp_ready)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      op_reg <= OP_READ_NO_SNOOP;
      orig_reg <= OP_READ_NO_SNOOP;
      addr_reg <= '0;
      base_reg <= '0;
      full_reg <= 1'b0;
      cache_reg <= 4'h0;
      dom_reg <= DOM_NSH;
      peer_reg <= 1'b0;
      ds_reg <= 1'b0;
      widen_reg <= 1'b0;
      split_reg <= 1'b0;
      part_reg <= '0;
      err_reg <= 1'b0;
      shared_reg <= 1'b0;
      dirty_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      orig_reg <= orig_next;
      addr_reg <= addr_next;
      base_reg <= base_next;
      full_reg <= full_next;
      cache_reg <= cache_next;
      dom_reg <= dom_next;
      peer_reg <= peer_next;
      ds_reg <= ds_next;
      widen_reg <= widen_next;
      split_reg <= split_next;
      part_reg <= part_next;
      err_reg <= err_next;
      shared_reg <= shared_next;
      dirty_reg <= dirty_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign up_ready = (state_reg == ST_IDLE);
  assign dn_valid = (state_reg == ST_ISSUE);
  assign sr_ready = (state_reg == ST_WAIT);
  assign wb_valid = (state_reg == ST_WB);
  assign rsp_valid = (state_reg == ST_RESP);
  assign dn_op = op_reg;
  assign dn_addr = addr_reg;
  assign dn_full = full_reg;
  assign dn_cache = cache_reg;
  assign dn_domain = dom_reg;
  assign dn_peer_snoop = peer_reg;
  assign dn_ds_maint = ds_reg;
  assign wb_addr = base_reg;
  assign rsp_shared = shared_reg;
  assign rsp_dirty = dirty_reg;
  assign rsp_err = err_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_widen_align: assert property (@(posedge ref_clk) disable iff (!rstn)
    (dn_valid && widen_reg) |-> (dn_addr[WOFF-1:0] == '0))
    else $error("widened request not aligned to wide line");

  chk_make_conv: assert property (@(posedge ref_clk) disable iff (!rstn)
    (dn_valid && widen_reg) |-> !(dn_op inside {OP_MAKE_UNIQUE, OP_MAKE_INVALID}))
    else $error("widened make request not converted");

  chk_split_count: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_WAIT && sr_valid && split_reg && part_reg == LAST_PART)
    |=> (state_reg inside {ST_WB, ST_RESP}))
    else $error("split response not closed after last part");

  chk_split_contig: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_WAIT && sr_valid && split_reg && part_reg != LAST_PART)
    |=> (dn_valid && $changed(dn_addr)))
    else $error("split parts not issued back to back");

  chk_shared_merge: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_reg == ST_WAIT && sr_valid && sr_shared && !(split_reg && part_reg != LAST_PART))
    |=> (rsp_valid || wb_valid) && rsp_shared)
    else $error("shared part not reported as shared line");

  chk_dirty_single: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wb_valid && wb_ready) |=> (rsp_valid && !rsp_dirty))
    else $error("line both written back and handed dirty");

  chk_full_snoop: assert property (@(posedge ref_clk) disable iff (!rstn)
    (dn_valid && is_snoop(dn_op)) |-> dn_full)
    else $error("snoop issued below full line");

  chk_win_prefix: assert property (@(posedge ref_clk) disable iff (!rstn)
    dn_valid |-> (dn_addr[WIDE_AW-1:NARROW_AW] == WIN_BASE))
    else $error("outgoing address lacks window bits");

  chk_partial_err: assert property (@(posedge ref_clk) disable iff (!rstn)
    (up_valid && up_ready && !up_full && !may_partial(up_op))
    |=> (rsp_valid && rsp_err && !dn_valid))
    else $error("illegal partial request not refused");
endmodule : cla_top

// ---- tb/cla_far_model.sv ----
// Far side model: downstream target, snooped caches and memory
`timescale 1ns/1ps
module cla_far_model (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // Downstream request
  input logic dn_valid,
  output logic dn_ready,
  input cla_pkg::cla_op_e dn_op,
  input logic [39:0] dn_addr,
  input logic dn_full,
  // Part response and memory write
  output logic sr_valid,
  input logic sr_ready,
  output logic sr_shared,
  output logic sr_dirty,
  input logic wb_valid,
  output logic wb_ready,
  input logic [39:0] wb_addr,
  // Answer pattern per part, picked by address bit 5
  input logic [1:0] sh_pat,
  input logic [1:0] dt_pat
);
  import cla_pkg::*;
  int n_dn; // Parts taken
  int n_wb; // Memory writes taken
  cla_op_e op_log [16];
  logic [39:0] ad_log [16];
  logic fl_log [16];
  logic [39:0] wb_last;
  // Ready one cycle late, so each downstream and memory write handshake waits once
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      {dn_ready, sr_valid, wb_ready, sr_shared, sr_dirty} <= 5'h00;
      n_dn <= 0;
      n_wb <= 0;
    end
    else
    begin
      dn_ready <= dn_valid && !dn_ready;
      wb_ready <= wb_valid && !wb_ready;
      if (dn_valid && dn_ready)
      begin
        op_log[n_dn[3:0]] <= dn_op;
        ad_log[n_dn[3:0]] <= dn_addr;
        fl_log[n_dn[3:0]] <= dn_full;
        n_dn <= n_dn + 1;
        sr_valid <= 1'h1;
        sr_shared <= sh_pat[dn_addr[5]];
        sr_dirty <= dt_pat[dn_addr[5]];
      end
      else if (sr_valid && sr_ready)
      begin
        // Released lines flip so stale values never look valid
        sr_valid <= 1'h0;
        sr_shared <= ~sr_shared;
        sr_dirty <= ~sr_dirty;
      end
      if (wb_valid && wb_ready)
      begin
        n_wb <= n_wb + 1;
        wb_last <= wb_addr;
      end
    end
  end
endmodule : cla_far_model

// ---- tb/tb_cla_top.sv ----
// Self-checking bench for the coherent line size adapter
`timescale 1ns/1ps
module tb_cla_top;
  import cla_pkg::*;
  logic ref_clk = 0, rstn = 0;
  logic up_valid = 0, up_wide = 0, up_full = 0, up_ready;
  cla_op_e up_op = OP_READ_NO_SNOOP, dn_op, in_op = OP_READ_ONCE, sm_op;
  logic [31:0] up_addr = '0, sm_addr;
  logic [3:0] up_cache = 4'hC, dn_cache;
  cla_dom_e up_domain = DOM_NSH, dn_domain;
  logic dn_valid, dn_ready, dn_full, dn_peer_snoop, dn_ds_maint;
  logic sr_valid, sr_ready, sr_shared, sr_dirty, wb_valid, wb_ready;
  logic [39:0] dn_addr, wb_addr, in_addr = '0;
  logic rsp_valid, rsp_ready = 1, rsp_shared, rsp_dirty, rsp_err;
  logic in_valid = 0, in_ready, in_drop, sm_valid, sm_ready = 1;
  logic [1:0] sh_pat = '0, dt_pat = '0;
  logic r_sh, r_dt, r_er; // Response fields of the last transaction
  int n_fail = 0, checked = 0, d0, w0;
  cla_top dut (.*);
  cla_far_model pm (.*);
  always #5 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // One transaction, entered and left on a rising edge
  task automatic run(cla_op_e op, logic [31:0] a, logic w, f, cla_dom_e dm,
    logic [1:0] sh, dt);
    d0 = pm.n_dn;
    w0 = pm.n_wb;
    up_op <= op;
    up_domain <= dm;
    {up_addr, up_wide, up_full} <= {a, w, f};
    {sh_pat, dt_pat, up_valid} <= {sh, dt, 1'h1};
    @(negedge ref_clk);
    for (int i = 0; i < 50 && up_ready !== 1'h1; i++) @(negedge ref_clk);
    chk("up_ready", 1, up_ready);
    @(posedge ref_clk);
    up_valid <= 1'h0;
    @(negedge ref_clk);
    for (int i = 0; i < 50 && rsp_valid !== 1'h1; i++) @(negedge ref_clk);
    chk("rsp_valid", 1, rsp_valid);
    {r_sh, r_dt, r_er} = {rsp_shared, rsp_dirty, rsp_err};
    @(posedge ref_clk);
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_read_dirty();
    run(OP_READ_SHARED, 32'h00001234, 0, 1, DOM_INNER, 2'h0, 2'h3);
    chk("dn_addr", 40'h0000001200, pm.ad_log[d0[3:0]]);
    chk("wb_count", 1, pm.n_wb - w0);
    chk("wb_addr", 40'h0000001200, pm.wb_last);
    chk("rsp_dirty", 0, r_dt);
    chk("peer", 1, dn_peer_snoop);
    run(OP_CLEAN_SHARED, 32'h00002000, 0, 1, DOM_OUTER, 2'h0, 2'h3);
    chk("clean_wb", 1, pm.n_wb - w0);
    chk("ds_maint", 1, dn_ds_maint);
    chk("cache", 4'hC, dn_cache);
    chk("domain", DOM_OUTER, dn_domain);
  endtask : s_read_dirty
  task automatic s_make();
    cla_op_e ops [2] = '{OP_MAKE_UNIQUE, OP_MAKE_INVALID};
    foreach (ops[k])
    begin
      run(ops[k], 32'h00000040, 0, 1, DOM_INNER, 2'h0, 2'h3);
      chk("make_op", OP_CLEAN_INVALID, pm.op_log[d0[3:0]]);
      chk("make_wb", 1, pm.n_wb - w0);
    end
    // Wide master invalidate: split, dirty dropped, no allocate bits
    up_cache <= 4'h3;
    run(OP_MAKE_INVALID, 32'h00000040, 1, 1, DOM_NSH, 2'h0, 2'h3);
    chk("mi_op", OP_MAKE_INVALID, pm.op_log[d0[3:0]]);
    chk("mi_no_wb", 0, pm.n_wb - w0);
    chk("mi_dirty", 0, r_dt);
    chk("mi_ds", 0, dn_ds_maint);
    chk("mi_peer", 0, dn_peer_snoop);
    up_cache <= 4'hC;
  endtask : s_make
  task automatic s_split();
    run(OP_READ_SHARED, 32'h00001020, 1, 1, DOM_INNER, 2'h2, 2'h1);
    chk("parts", 2, pm.n_dn - d0);
    chk("part0", 40'h0000001000, pm.ad_log[d0[3:0]]);
    chk("part1", 40'h0000001020, pm.ad_log[4'(d0 + 1)]);
    chk("shared", 1, r_sh);
    chk("dirty", 1, r_dt);
    chk("no_wb", 0, pm.n_wb - w0);
  endtask : s_split
  task automatic s_partial();
    run(OP_READ_CLEAN, 32'h00000080, 0, 0, DOM_INNER, 2'h0, 2'h0);
    chk("err_size", 1, r_er);
    chk("no_dn", 0, pm.n_dn - d0);
    run(OP_CLEAN_INVALID, 32'h00000080, 0, 1, DOM_SYS, 2'h0, 2'h0);
    chk("err_sys", 1, r_er);
    run(OP_READ_ONCE, 32'h00000084, 0, 0, DOM_INNER, 2'h0, 2'h0);
    chk("ok_once", 0, r_er);
    chk("once_full", 1, pm.fl_log[d0[3:0]]);
    run(OP_WRITE_UNIQUE, 32'h00000088, 0, 0, DOM_INNER, 2'h0, 2'h0);
    chk("wu_op", OP_CLEAN_INVALID, pm.op_log[d0[3:0]]);
    chk("wu_addr", 40'h0000000080, pm.ad_log[d0[3:0]]);
  endtask : s_partial
  task automatic win(logic [39:0] a);
    {in_addr, in_valid} <= {a, 1'h1};
    @(posedge ref_clk);
    in_valid <= 1'h0;
    @(negedge ref_clk);
  endtask : win
  task automatic s_window();
    win(40'h0080000010);
    chk("sm_valid", 1, sm_valid);
    chk("sm_addr", 32'h80000010, sm_addr);
    chk("sm_op", OP_READ_ONCE, sm_op);
    @(posedge ref_clk);
    win(40'h0500000010);
    chk("in_drop", 1, in_drop);
    chk("sm_quiet", 0, sm_valid);
  endtask : s_window
  // Main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'h1;
    s_read_dirty();
    s_make();
    s_split();
    s_partial();
    s_window();
    give_verdict();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    give_verdict();
  end
endmodule : tb_cla_top
